// [rtl/cas_cfg.svh]
// constants and functional notes for the channel alarm and unit status bank
// Functional notes
// RULE1 - four channel alarm words at offsets 0102, 0202, 0302, 0402
// RULE2 - bits 0..2 show alarm 1, 2, 3 active
// RULE3 - bit 4 shows heater overcurrent error on the channel
// RULE4 - bit 5 shows heater-break alarm on
// RULE5 - bit 6 shows heater-short alarm on
// RULE6 - bit 7 shows output-overcurrent alarm on
// RULE7 - bit 12 set when set point lies outside limiter range
// RULE8 - bit 13 set when upper set point limit is below lower
// RULE9 - bit 14 set when upper output value limit is below lower
// RULE10 - bit 15 set when upper scaling limit is below lower
// RULE11 - unit bit 20 shows write mode, 1 means working RAM only
// RULE12 - unit bit 21 shows RAM differs from nonvolatile copy
// RULE13 - unit bit 25 always reads 1
// RULE14 - unused bits read 0; host writes have no effect
// RULE15 - bits follow live conditions and clear themselves, no acknowledge
`ifndef CAS_CFG_SVH
`define CAS_CFG_SVH
`define CAS_IDX_UNIT      16'h0001
`define CAS_IDX_CH1       16'h0102
`define CAS_IDX_CH2       16'h0202
`define CAS_IDX_CH3       16'h0302
`define CAS_IDX_CH4       16'h0402
`define CAS_IDX_W         16
`define CAS_NCH           4
`define CAS_BIT_ALM1      0
`define CAS_BIT_ALM2      1
`define CAS_BIT_ALM3      2
`define CAS_BIT_HOC       4
`define CAS_BIT_HB        5
`define CAS_BIT_HS        6
`define CAS_BIT_OC        7
`define CAS_BIT_SPRANGE   12
`define CAS_BIT_SPREV     13
`define CAS_BIT_MVREV     14
`define CAS_BIT_SCREV     15
`define CAS_BIT_WMODE     20
`define CAS_BIT_NVDIFF    21
`define CAS_BIT_COMWR     25
`define CAS_HTRANS_NSEQ   2
`define CAS_HTRANS_SEQ    3
`define CAS_ZERO32        32'h00000000
`define CAS_ZERO16        16'h0000
`endif

// [rtl/cas_pkg.sv]
// types shared by the status bank
package cas_pkg;
  typedef logic [15:0] cas_val_t;
  typedef logic [15:0] cas_word_t;
  typedef enum logic [1:0] {
    CAS_IDLE = 2'b01,
    CAS_DATA = 2'b10
  } cas_state_t;
  typedef struct packed {
    cas_state_t  state;
    logic [31:0] hrdata;
    cas_word_t [3:0] chWord;
    logic        writeMode;
    logic        nvDiff;
  } cas_regs_t;
endpackage : cas_pkg

// [rtl/cas_channel.sv]
// one channel alarm word built from synchronised flags and configured limits
`include "cas_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cas_channel (
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire logic [7:0]      alarmIn,
  input  wire cas_pkg::cas_val_t setPoint,
  input  wire cas_pkg::cas_val_t spLimitLow,
  input  wire cas_pkg::cas_val_t spLimitHigh,
  input  wire cas_pkg::cas_val_t mvLimitLow,
  input  wire cas_pkg::cas_val_t mvLimitHigh,
  input  wire cas_pkg::cas_val_t scaleLow,
  input  wire cas_pkg::cas_val_t scaleHigh,
  output logic [15:0]          word
);
  import cas_pkg::*;
  // alarm flags come from other logic off this clock: two stages first
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end else begin
      sync1_r <= alarmIn;
      sync2_r <= sync1_r;
    end
  end
  // limits are signed engineering values
  always_comb begin
    word = `CAS_ZERO16; // see RULE14
    word[`CAS_BIT_ALM1] = sync2_r[0]; // see RULE2
    word[`CAS_BIT_ALM2] = sync2_r[1]; // see RULE2
    word[`CAS_BIT_ALM3] = sync2_r[2]; // see RULE2
    word[`CAS_BIT_HOC] = sync2_r[4]; // see RULE3
    word[`CAS_BIT_HB] = sync2_r[5]; // see RULE4
    word[`CAS_BIT_HS] = sync2_r[6]; // see RULE5
    word[`CAS_BIT_OC] = sync2_r[7]; // see RULE6
    word[`CAS_BIT_SPRANGE] = ($signed(setPoint) < $signed(spLimitLow)) ||
                             ($signed(setPoint) > $signed(spLimitHigh)); // see RULE7
    word[`CAS_BIT_SPREV] = $signed(spLimitHigh) < $signed(spLimitLow); // see RULE8
    word[`CAS_BIT_MVREV] = $signed(mvLimitHigh) < $signed(mvLimitLow); // see RULE9
    word[`CAS_BIT_SCREV] = $signed(scaleHigh) < $signed(scaleLow); // see RULE10
  end
  spRev_a: assert property (@(posedge clk) disable iff (!reset_n)
    word[`CAS_BIT_SPREV] == ($signed(spLimitHigh) < $signed(spLimitLow)))
    else $error("set point reverse flag wrong"); // see RULE8
  almFollow_a: assert property (@(posedge clk) disable iff (!reset_n)
    ##2 word[`CAS_BIT_HB] == $past(alarmIn[5], 2))
    else $error("heater-break flag does not follow input"); // see RULE4
endmodule : cas_channel
`default_nettype wire

// [rtl/cas_status_bank.sv]
// ahb-lite read-only bank of channel alarm words and the unit status word
`include "cas_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cas_status_bank (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic [31:0]       alarmIn,
  input  wire cas_pkg::cas_val_t setPoint    [4],
  input  wire cas_pkg::cas_val_t spLimitLow  [4],
  input  wire cas_pkg::cas_val_t spLimitHigh [4],
  input  wire cas_pkg::cas_val_t mvLimitLow  [4],
  input  wire cas_pkg::cas_val_t mvLimitHigh [4],
  input  wire cas_pkg::cas_val_t scaleLow    [4],
  input  wire cas_pkg::cas_val_t scaleHigh   [4],
  input  wire logic              ramWriteMode,
  input  wire logic              nvMismatch
);
  import cas_pkg::*;
  cas_regs_t regs_r;
  cas_regs_t regs_nxt;
  cas_word_t chLive [4];
  logic [1:0] unitSync_r;
  logic [1:0] unitMeta_r;
  logic       accept;
  logic [`CAS_IDX_W-1:0] idx;
  logic [31:0] unitWord;
  logic [31:0] readVal;

  genvar g;
  generate
    for (g = 0; g < `CAS_NCH; g++) begin : gCh
      cas_channel uCh (
        .clk         (clk),
        .reset_n     (reset_n),
        .alarmIn     (alarmIn[g*8 +: 8]),
        .setPoint    (setPoint[g]),
        .spLimitLow  (spLimitLow[g]),
        .spLimitHigh (spLimitHigh[g]),
        .mvLimitLow  (mvLimitLow[g]),
        .mvLimitHigh (mvLimitHigh[g]),
        .scaleLow    (scaleLow[g]),
        .scaleHigh   (scaleHigh[g]),
        .word        (chLive[g])
      );
    end
  endgenerate

  // unit flags are set by storage logic elsewhere, so synchronise
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      unitMeta_r <= 2'b00;
      unitSync_r <= 2'b00;
    end else begin
      unitMeta_r <= {nvMismatch, ramWriteMode};
      unitSync_r <= unitMeta_r;
    end
  end

  assign accept = hsel && hready &&
                  (htrans == 2'(`CAS_HTRANS_NSEQ) || htrans == 2'(`CAS_HTRANS_SEQ));
  // byte address is four times the printed index
  assign idx = haddr[`CAS_IDX_W+1:2];

  always_comb begin
    unitWord = `CAS_ZERO32; // see RULE14
    unitWord[`CAS_BIT_WMODE] = regs_r.writeMode; // see RULE11
    unitWord[`CAS_BIT_NVDIFF] = regs_r.nvDiff; // see RULE12
    unitWord[`CAS_BIT_COMWR] = 1'b1; // see RULE13
  end

  always_comb begin
    readVal = `CAS_ZERO32;
    // unmapped addresses read zero with an okay answer
    case (idx)
      `CAS_IDX_UNIT: readVal = unitWord;
      `CAS_IDX_CH1:  readVal = {16'h0000, regs_r.chWord[0]}; // see RULE1
      `CAS_IDX_CH2:  readVal = {16'h0000, regs_r.chWord[1]}; // see RULE1
      `CAS_IDX_CH3:  readVal = {16'h0000, regs_r.chWord[2]}; // see RULE1
      `CAS_IDX_CH4:  readVal = {16'h0000, regs_r.chWord[3]}; // see RULE1
      default:       readVal = `CAS_ZERO32;
    endcase
  end

  always_comb begin
    regs_nxt = regs_r;
    // live copies every cycle: nothing latches, nothing needs acknowledge
    for (int i = 0; i < `CAS_NCH; i++) begin
      regs_nxt.chWord[i] = chLive[i]; // see RULE15
    end
    regs_nxt.writeMode = unitSync_r[0]; // see RULE15
    regs_nxt.nvDiff = unitSync_r[1]; // see RULE15
    case (regs_r.state)
      CAS_IDLE: begin
        if (accept) begin
          regs_nxt.state = CAS_DATA;
          // writes are taken and dropped, the words are pure status
          regs_nxt.hrdata = hwrite ? `CAS_ZERO32 : readVal; // see RULE14
        end
      end
      CAS_DATA: begin
        if (accept) begin
          regs_nxt.hrdata = hwrite ? `CAS_ZERO32 : readVal; // see RULE14
        end else begin
          regs_nxt.state = CAS_IDLE;
          regs_nxt.hrdata = `CAS_ZERO32;
        end
      end
      default: begin
        regs_nxt.state = CAS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regs_r.state <= CAS_IDLE;
      regs_r.hrdata <= `CAS_ZERO32;
      regs_r.chWord <= '0;
      regs_r.writeMode <= 1'b0;
      regs_r.nvDiff <= 1'b0;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = regs_r.hrdata;

  comWr_a: assert property (@(posedge clk) disable iff (!reset_n)
    (accept && !hwrite && idx == `CAS_IDX_UNIT) |=> hrdata[`CAS_BIT_COMWR])
    else $error("comm write enable bit not one"); // see RULE13
  wMode_a: assert property (@(posedge clk) disable iff (!reset_n)
    (accept && !hwrite && idx == `CAS_IDX_UNIT) |=>
      hrdata[`CAS_BIT_WMODE] == $past(regs_r.writeMode))
    else $error("write mode bit wrong"); // see RULE11
  nvDiff_a: assert property (@(posedge clk) disable iff (!reset_n)
    (accept && !hwrite && idx == `CAS_IDX_UNIT) |=>
      hrdata[`CAS_BIT_NVDIFF] == $past(regs_r.nvDiff))
    else $error("nonvolatile mismatch bit wrong"); // see RULE12
  unitZero_a: assert property (@(posedge clk) disable iff (!reset_n)
    (accept && idx == `CAS_IDX_UNIT) |=> (hrdata & 32'hFDCFFFFF) == `CAS_ZERO32)
    else $error("unused unit bits not zero"); // see RULE14
  chUpper_a: assert property (@(posedge clk) disable iff (!reset_n)
    (accept && idx == `CAS_IDX_CH3) |=> hrdata[31:16] == `CAS_ZERO16)
    else $error("channel upper half not zero"); // see RULE14
  ch2Read_a: assert property (@(posedge clk) disable iff (!reset_n)
    (accept && !hwrite && idx == `CAS_IDX_CH2) |=> hrdata[15:0] == $past(chLive[1], 2))
    else $error("channel two word not returned"); // see RULE1
  chUnused_a: assert property (@(posedge clk) disable iff (!reset_n)
    (accept && idx == `CAS_IDX_CH1) |=> (hrdata & 32'h00000F08) == `CAS_ZERO32)
    else $error("unused channel bits not zero"); // see RULE14
  alarmLive_a: assert property (@(posedge clk) disable iff (!reset_n)
    ##4 regs_r.chWord[0][`CAS_BIT_ALM1] == $past(alarmIn[0], 3))
    else $error("alarm one not live"); // see RULE2
  wrZero_a: assert property (@(posedge clk) disable iff (!reset_n) // see RULE14
    (accept && hwrite) |=> hrdata == `CAS_ZERO32)
    else $error("write data phase returned status");
  ch4Read_a: assert property (@(posedge clk) disable iff (!reset_n) // see RULE1
    (accept && !hwrite && idx == `CAS_IDX_CH4) |=> hrdata[15:0] == $past(chLive[3], 2))
    else $error("channel four word not returned");
  idleZero_a: assert property (@(posedge clk) disable iff (!reset_n) // see RULE14
    (regs_r.state == CAS_IDLE) |-> hrdata == `CAS_ZERO32)
    else $error("read data not zero outside a data phase");
endmodule : cas_status_bank
`default_nettype wire

// [dv/cas_host.sv]
// host model: single ahb-lite word transfers into the status bank
`timescale 1ns/1ps
`default_nettype none
module cas_host (
  input  wire logic        clk,
  input  wire logic        hready,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
  end
  // bounded waits: ok stays low when the slave never answers
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic ok);
    int i;
    @(posedge clk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
    ok = 1'b0;
    for (i = 0; i < 50 && !ok; i++) begin
      @(posedge clk);
      ok = (hready === 1'b1);
    end
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    if (ok) begin
      ok = 1'b0;
      for (i = 0; i < 50 && !ok; i++) begin
        @(posedge clk);
        ok = (hready === 1'b1);
      end
    end
  endtask : xfer
endmodule : cas_host
`default_nettype wire

// [dv/channel_alarm_and_unit_status_tb.sv]
// self-checking bench for the status bank
`timescale 1ns/1ps
`default_nettype none
module channel_alarm_and_unit_status_tb;
  import cas_pkg::*;
  logic clk, reset_n, hsel, hwrite, hreadyout, hresp, ramWriteMode, nvMismatch, ok, rdPhase;
  logic [31:0] haddr, hwdata, hrdata, alarmIn;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  cas_val_t    sp [4], spL [4], spH [4], mvL [4], mvH [4], scL [4], scH [4];
  logic [31:0] expQ [$];
  logic [31:0] adr [7] = '{32'h4, 32'h408, 32'h808, 32'hC08, 32'h1008, 32'h0, 32'h40C};
  int fails = 0, check_count = 0;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  cas_host host (.clk(clk), .hready(hreadyout), .hsel(hsel), .haddr(haddr), .htrans(htrans),
                 .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  cas_status_bank DUT (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .alarmIn(alarmIn),
    .setPoint(sp), .spLimitLow(spL), .spLimitHigh(spH), .mvLimitLow(mvL),
    .mvLimitHigh(mvH), .scaleLow(scL), .scaleHigh(scH), .ramWriteMode(ramWriteMode),
    .nvMismatch(nvMismatch));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic summarize;
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  // expected word per address slot; limits compare as signed values
  function automatic logic [31:0] expOf(int i);
    int n;
    n = i - 1;
    if (i == 0) return 32'h02000000 | {10'h0, nvMismatch, ramWriteMode, 20'h0};
    if (i > 4) return 32'h0;
    return {16'h0, $signed(scH[n]) < $signed(scL[n]), $signed(mvH[n]) < $signed(mvL[n]),
            $signed(spH[n]) < $signed(spL[n]),
            $signed(sp[n]) < $signed(spL[n]) || $signed(sp[n]) > $signed(spH[n]),
            4'h0, alarmIn[8*n +: 8] & 8'hF7};
  endfunction : expOf

  // result watcher: a read data phase ends where hready is high
  always @(posedge clk) begin
    if (rdPhase) begin
      check("hreadyout", {31'h0, hreadyout}, 32'h1);
    end
    if (rdPhase && hreadyout === 1'b1) begin
      check("hrdata", hrdata, expQ.size() ? expQ.pop_front() : 32'hDEADBEEF);
      check("hresp", {31'h0, hresp}, 32'h0);
    end
    rdPhase <= hsel && htrans == 2'h2 && !hwrite && hreadyout === 1'b1;
  end

  initial begin
    int t, k;
    ok = 1'b1; reset_n = 1'b0; alarmIn = 32'h0; ramWriteMode = 1'b0; nvMismatch = 1'b0;
    for (k = 0; k < 4; k++) begin
      sp[k] = 16'h0; spL[k] = 16'h0; spH[k] = 16'h0; mvL[k] = 16'h0; mvH[k] = 16'h0;
      scL[k] = 16'h0; scH[k] = 16'h0;
    end
    void'($urandom(51));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (t = 0; t < 24 && ok; t++) begin
      @(posedge clk);
      alarmIn <= (t == 23) ? 32'h0 : $urandom;
      ramWriteMode <= t[0];
      nvMismatch <= t[1];
      for (k = 0; k < 4; k++) begin
        sp[k] <= 16'($urandom); spL[k] <= 16'($urandom); spH[k] <= 16'($urandom);
        mvL[k] <= 16'($urandom); mvH[k] <= 16'($urandom);
        scL[k] <= 16'($urandom); scH[k] <= 16'($urandom);
      end
      repeat (6) @(posedge clk);
      // a write of all ones must leave every word as it was
      for (k = 0; k < 7 && ok; k++) begin
        host.xfer(adr[k], 1'b1, 32'hFFFFFFFF, ok);
        if (ok) begin
          expQ.push_back(expOf(k));
          host.xfer(adr[k], 1'b0, 32'h0, ok);
        end
      end
    end
    // a transfer that timed out counts once and goes to the report
    if (!ok) fails++;
    repeat (3) @(posedge clk);
    check("pending", expQ.size(), 32'h0);
    summarize();
  end
endmodule : channel_alarm_and_unit_status_tb
`default_nettype wire
